/* hdl/jdp_debug_port.sv */
// Test access port and open-drain debug-event handshake
`timescale 1ns/100ps
module jdp_debug_port #(
    parameter int ACK_CYCLES = jdp_pkg::ACK_CYCLES
) (
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire jdp_pkg::jdp_pins_t pinsIn,
    input  wire logic              debugEventIn,
    input  wire logic              debugResume,
    output logic                   tdoOut,
    output logic                   tdoOe_n,
    output logic                   debugEventOut,
    output logic                   debugEventOe_n,
    output logic                   debugMode
);
    import jdp_pkg::*;

    localparam int CNT_W = $clog2(ACK_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(ACK_CYCLES);

    jdp_pins_t pins;
    logic      eventSync;

    jdp_sync #(
        .W   (5),
        .RST ({PINS_IDLE, 1'b1})
    ) u_sync (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .din     ({pinsIn, debugEventIn}),
        .dout    ({pins, eventSync})
    );

    function automatic jdp_tap_t tapNext(input jdp_tap_t s, input logic tms);
        case (s)
            TAP_RESET:    tapNext = tms ? TAP_RESET    : TAP_IDLE;
            TAP_IDLE:     tapNext = tms ? TAP_SEL_DR   : TAP_IDLE;
            TAP_SEL_DR:   tapNext = tms ? TAP_SEL_IR   : TAP_CAP_DR;
            TAP_CAP_DR:   tapNext = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tapNext = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tapNext = tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tapNext = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tapNext = tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
            TAP_UPD_DR:   tapNext = tms ? TAP_SEL_DR   : TAP_IDLE;
            TAP_SEL_IR:   tapNext = tms ? TAP_RESET    : TAP_CAP_IR;
            TAP_CAP_IR:   tapNext = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tapNext = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tapNext = tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tapNext = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tapNext = tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
            TAP_UPD_IR:   tapNext = tms ? TAP_SEL_DR   : TAP_IDLE;
            default:      tapNext = TAP_RESET;
        endcase
    endfunction : tapNext

    // Test clock edges found by the system clock
    logic tckPrev_q;
    logic tckRise;
    logic tckFall;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tckPrev_q <= 1'b0;
        end else begin
            tckPrev_q <= pins.tck;
        end
    end

    assign tckRise = pins.tck & ~tckPrev_q;
    assign tckFall = ~pins.tck & tckPrev_q;

    // Controller, instruction and data registers
    jdp_tap_t          state_q;
    jdp_tap_t          state_d;
    logic [IR_W-1:0]   ir_q;
    logic [IR_W-1:0]   ir_d;
    logic [IR_W-1:0]   irShift_q;
    logic [IR_W-1:0]   irShift_d;
    logic [DR_W-1:0]   drShift_q;
    logic [DR_W-1:0]   drShift_d;
    logic              bypass_q;
    logic              bypass_d;

    always_comb begin
        state_d   = state_q;
        ir_d      = ir_q;
        irShift_d = irShift_q;
        drShift_d = drShift_q;
        bypass_d  = bypass_q;
        if (!pins.trstN) begin
            state_d = TAP_RESET;
            ir_d    = IR_IDCODE;
        end else if (tckRise) begin
            state_d = tapNext(state_q, pins.tms);
            case (state_q)
                TAP_CAP_IR:   irShift_d = IR_CAPTURE;
                TAP_SHIFT_IR: irShift_d = {pins.tdi, irShift_q[IR_W-1:1]};
                TAP_CAP_DR: begin
                    drShift_d = (ir_q == IR_IDCODE) ? IDCODE_VALUE : DR_ZERO;
                    bypass_d  = 1'b0;
                end
                TAP_SHIFT_DR: begin
                    drShift_d = {pins.tdi, drShift_q[DR_W-1:1]};
                    bypass_d  = pins.tdi;
                end
                default: begin
                end
            endcase
        end else if (tckFall) begin
            case (state_q)
                TAP_RESET:  ir_d = IR_IDCODE;
                TAP_UPD_IR: ir_d = irShift_q;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q   <= TAP_RESET;
            ir_q      <= IR_IDCODE;
            irShift_q <= IR_CAPTURE;
            drShift_q <= DR_ZERO;
            bypass_q  <= 1'b0;
        end else begin
            state_q   <= state_d;
            ir_q      <= ir_d;
            irShift_q <= irShift_d;
            drShift_q <= drShift_d;
            bypass_q  <= bypass_d;
        end
    end

    // Serial output, moved on the falling edge so the far end samples a settled bit
    logic tdo_d;
    logic tdoOe_n_d;
    logic shifting;
    logic tdoSrc;

    always_comb begin
        shifting  = (state_q == TAP_SHIFT_IR) || (state_q == TAP_SHIFT_DR);
        tdoSrc    = bypass_q;
        if (state_q == TAP_SHIFT_IR) begin
            tdoSrc = irShift_q[0];
        end else if (ir_q == IR_IDCODE) begin
            tdoSrc = drShift_q[0];
        end
        tdo_d     = tdoOut;
        tdoOe_n_d = tdoOe_n;
        if (!pins.trstN) begin
            tdoOe_n_d = 1'b1;
        end else if (tckFall) begin
            tdo_d     = tdoSrc;
            tdoOe_n_d = ~shifting;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tdoOut  <= 1'b0;
            tdoOe_n <= 1'b1;
        end else begin
            tdoOut  <= tdo_d;
            tdoOe_n <= tdoOe_n_d;
        end
    end

    // Debug entry and acknowledge on the shared open-drain pin
    logic             tapDbgReq;
    logic             pinDbgReq;
    logic             enterDbg;
    logic             debugMode_d;
    logic [CNT_W-1:0] ackCnt_q;
    logic [CNT_W-1:0] ackCnt_d;
    logic             eventOe_n_d;

    assign tapDbgReq = tckFall && (state_q == TAP_UPD_IR) && (irShift_q == IR_DEBUG);
    // Own acknowledge reads back low, so the pin is ignored while in debug mode
    assign pinDbgReq = ~eventSync & ~debugMode;

    always_comb begin
        enterDbg    = (pinDbgReq || tapDbgReq) && !debugMode;
        debugMode_d = debugMode;
        ackCnt_d    = ackCnt_q;
        if (enterDbg) begin
            debugMode_d = 1'b1;
            ackCnt_d    = CNT_LOAD;
        end else begin
            if (debugResume && ackCnt_q == CNT_ZERO) begin
                debugMode_d = 1'b0;
            end
            if (ackCnt_q != CNT_ZERO) begin
                ackCnt_d = ackCnt_q - 1'b1;
            end
        end
        eventOe_n_d = (ackCnt_d == CNT_ZERO);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            debugMode      <= 1'b0;
            ackCnt_q       <= CNT_ZERO;
            debugEventOe_n <= 1'b1;
            debugEventOut  <= 1'b0;
        end else begin
            debugMode      <= debugMode_d;
            ackCnt_q       <= ackCnt_d;
            debugEventOe_n <= eventOe_n_d;
            debugEventOut  <= 1'b0;
        end
    end
endmodule : jdp_debug_port

/* hdl/jdp_pkg.sv */
// Constants, state codes and pin bundle for the test and debug-event port
package jdp_pkg;
    localparam int          IR_W         = 4;
    localparam int          DR_W         = 32;
    localparam logic [3:0]  IR_IDCODE    = 4'h2;
    localparam logic [3:0]  IR_DEBUG     = 4'h7;
    localparam logic [3:0]  IR_BYPASS    = 4'hF;
    localparam logic [3:0]  IR_CAPTURE   = 4'h1;
    // Arbitrary identification value, names no real part
    localparam logic [31:0] IDCODE_VALUE = 32'h0ABC_0001;
    localparam logic [31:0] DR_ZERO      = 32'h0000_0000;

    localparam int CLK_PERIOD_NS = 25;
    localparam int ACK_TIME_NS   = 1000;
    localparam int ACK_CYCLES    = (ACK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [15:0] {
        TAP_RESET     = 16'h0001,
        TAP_IDLE      = 16'h0002,
        TAP_SEL_DR    = 16'h0004,
        TAP_CAP_DR    = 16'h0008,
        TAP_SHIFT_DR  = 16'h0010,
        TAP_EXIT1_DR  = 16'h0020,
        TAP_PAUSE_DR  = 16'h0040,
        TAP_EXIT2_DR  = 16'h0080,
        TAP_UPD_DR    = 16'h0100,
        TAP_SEL_IR    = 16'h0200,
        TAP_CAP_IR    = 16'h0400,
        TAP_SHIFT_IR  = 16'h0800,
        TAP_EXIT1_IR  = 16'h1000,
        TAP_PAUSE_IR  = 16'h2000,
        TAP_EXIT2_IR  = 16'h4000,
        TAP_UPD_IR    = 16'h8000
    } jdp_tap_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trstN;
    } jdp_pins_t;

    // Pad pull-ups idle high; clock idles low
    localparam jdp_pins_t PINS_IDLE = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trstN: 1'b1};
endpackage : jdp_pkg

/* hdl/jdp_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module jdp_sync #(
    parameter int             W   = 1,
    parameter logic [W-1:0]   RST = '0
) (
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;

    // First stage is read by the second stage only
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= RST;
            dout   <= RST;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule : jdp_sync

/* verification/jdp_debug_port_assertions.sv */
// Concurrent checks on the test port and debug pin
`timescale 1ns/100ps
module jdp_debug_port_assertions #(
    parameter int ACK_CYCLES = 4
) (
    input wire logic               sys_clk,
    input wire logic               rstn,
    input wire jdp_pkg::jdp_pins_t pinsIn,
    input wire logic               debugEventIn,
    input wire logic               debugResume,
    input wire logic               tdoOut,
    input wire logic               tdoOe_n,
    input wire logic               debugEventOut,
    input wire logic               debugEventOe_n,
    input wire logic               debugMode
);
    import jdp_pkg::*;
    logic [7:0] ackCnt_d, ackCnt_q, tmsRun_d, tmsRun_q;
    logic       tck_d, tck_q;
    // Run of TMS-high rises saturates so it never wraps back to zero
    always_comb begin
        ackCnt_d = debugEventOe_n ? 8'h00 : ackCnt_q + 8'h01;
        tck_d    = pinsIn.tck;
        tmsRun_d = tmsRun_q;
        if (pinsIn.tck && !tck_q) begin
            tmsRun_d = !pinsIn.tms ? 8'h00 : (tmsRun_q == 8'h08) ? 8'h08 : tmsRun_q + 8'h01;
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ackCnt_q <= 8'h00;
            tmsRun_q <= 8'h00;
            tck_q    <= 1'b0;
        end else begin
            ackCnt_q <= ackCnt_d;
            tmsRun_q <= tmsRun_d;
            tck_q    <= tck_d;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_req;
        $fell(debugEventIn) && !debugMode;
    endsequence
    sequence s_ack;
        debugMode && !debugEventOe_n;
    endsequence
    a_tdo_on_fall: assert property (($changed(tdoOut) || $changed(tdoOe_n)) && pinsIn.trstN
        |-> !$past(pinsIn.tck)) else $error("TDO moved outside a test clock fall");
    a_debug_entry: assert property (s_req |-> ##[1:4] s_ack) else $error("No debug entry");
    a_ack_width: assert property ($rose(debugEventOe_n) |-> ackCnt_q == 8'(ACK_CYCLES))
        else $error("Acknowledge pulse width wrong");
    a_ack_in_mode: assert property (!debugEventOe_n |-> debugMode) else $error("Stray ack");
    a_pin_never_high: assert property (debugEventOut == 1'b0) else $error("Debug pin driven");
    a_resume_exit: assert property (debugMode && debugResume && debugEventOe_n |=> !debugMode)
        else $error("Resume ignored");
    a_trst_quiet: assert property (!pinsIn.trstN [*6] |-> tdoOe_n) else $error("TDO on in reset");
    a_five_tms: assert property (tmsRun_q >= 8'h05 |-> tdoOe_n) else $error("TDO on after TMS run");
endmodule : jdp_debug_port_assertions

bind jdp_debug_port jdp_debug_port_assertions #(.ACK_CYCLES(ACK_CYCLES)) u_chk (
    .sys_clk(sys_clk), .rstn(rstn), .pinsIn(pinsIn), .debugEventIn(debugEventIn),
    .debugResume(debugResume), .tdoOut(tdoOut), .tdoOe_n(tdoOe_n),
    .debugEventOut(debugEventOut), .debugEventOe_n(debugEventOe_n), .debugMode(debugMode));

/* verification/jdp_debug_port_tb.sv */
// Self-checking bench for the test port and debug pin
`timescale 1ns/100ps
module jdp_debug_port_tb;
    import jdp_pkg::*;
    logic        sys_clk;
    logic        rstn;
    logic        debugResume;
    logic        tdoOut, tdoOe_n, debugEventOut, debugEventOe_n, debugMode;
    logic        hostPull_n, debugEventIn;
    logic [31:0] rd;
    jdp_pins_t   pins;
    int          badCount = 0;
    int          totalChecks = 0;
    int          cycles = 0;
    always #12.5 sys_clk = ~sys_clk;
    assign debugEventIn = hostPull_n & (debugEventOe_n | debugEventOut);
    jdp_debug_port #(.ACK_CYCLES(4)) dut (.sys_clk(sys_clk), .rstn(rstn), .pinsIn(pins),
        .debugEventIn(debugEventIn), .debugResume(debugResume), .tdoOut(tdoOut),
        .tdoOe_n(tdoOe_n), .debugEventOut(debugEventOut), .debugEventOe_n(debugEventOe_n),
        .debugMode(debugMode));
    jdp_jtag_host host (.sys_clk(sys_clk), .tdoOut(tdoOut), .tdoOe_n(tdoOe_n), .pins(pins),
        .hostPull_n(hostPull_n));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp) begin
            badCount++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic completeRun;
        $display("checks %0d mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : completeRun
    task automatic irScan(input logic [3:0] code);
        host.move(8'h06, 5);
        host.shift(4, {28'h0000000, code}, rd);
        chk("ir capture", {28'h0000000, IR_CAPTURE}, rd);
        host.move(8'h01, 2);
    endtask : irScan
    task automatic readId;
        host.move(8'h02, 4);
        host.shift(32, 32'h0000_0000, rd);
        chk("idcode", IDCODE_VALUE, rd);
        host.move(8'h01, 2);
        chk("tdo released", 32'h1, 32'(tdoOe_n));
    endtask : readId
    task automatic leave;
        repeat (8) @(posedge sys_clk);
        debugResume <= 1'b1;
        @(posedge sys_clk) debugResume <= 1'b0;
        @(negedge sys_clk);
        chk("debug left", 32'h0, 32'(debugMode));
    endtask : leave
    task automatic waitMode;
        for (int i = 0; i < 40 && debugMode !== 1'b1; i++) @(negedge sys_clk);
        chk("debug mode", 32'h1, 32'(debugMode));
    endtask : waitMode
    task automatic tBypass;
        irScan(4'hF);
        host.move(8'h01, 3);
        host.shift(8, 32'hA5, rd);
        chk("bypass", 32'h4A, rd);
        host.move(8'h01, 2);
    endtask : tBypass
    task automatic tFive;
        host.move(8'h01, 3);
        repeat (4) @(posedge sys_clk);
        chk("tdo driven", 32'h0, 32'(tdoOe_n));
        host.move(8'h1F, 5);
        readId();
    endtask : tFive
    task automatic tTrst;
        irScan(4'hF);
        host.move(8'h01, 3);
        host.setTrst(1'b0);
        repeat (8) @(posedge sys_clk);
        chk("tdo after trst", 32'h1, 32'(tdoOe_n));
        host.setTrst(1'b1);
        readId();
    endtask : tTrst
    task automatic tDbgPin;
        host.pull(1'b0);
        waitMode();
        chk("ack pull", 32'h0, 32'(debugEventOe_n));
        @(posedge sys_clk) debugResume <= 1'b1;
        // Resume must be sampled while the acknowledge still pulls
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk("resume refused", 32'h1, 32'(debugMode));
        @(posedge sys_clk) debugResume <= 1'b0;
        host.pull(1'b1);
        leave();
    endtask : tDbgPin
    task automatic tDbgIr;
        irScan(IR_DEBUG);
        waitMode();
        leave();
    endtask : tDbgIr
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 8000) begin
            badCount++;
            completeRun();
        end
    end
    initial begin
        sys_clk = 1'b0;
        rstn = 1'b0;
        debugResume = 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk("tdo at power-up", 32'h1, 32'(tdoOe_n));
        host.setTrst(1'b1);
        repeat (4) @(posedge sys_clk);
        tBypass();
        tFive();
        tTrst();
        tDbgPin();
        tDbgIr();
        completeRun();
    end
endmodule : jdp_debug_port_tb

/* verification/jdp_jtag_host.sv */
// Behavioural external test controller
`timescale 1ns/100ps
module jdp_jtag_host (
    input  wire logic          sys_clk,
    input  wire logic          tdoOut,
    input  wire logic          tdoOe_n,
    output jdp_pkg::jdp_pins_t pins,
    output logic               hostPull_n
);
    import jdp_pkg::*;
    initial begin
        pins       = PINS_IDLE;
        pins.trstN = 1'b0;
        hostPull_n = 1'b1;
    end
    // Clock stands low between calls; TDO read late in the low half
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        @(posedge sys_clk) pins.tms <= tms;
        pins.tdi <= tdi;
        // Low half is this edge plus three more, so one test clock is 8 cycles
        repeat (3) @(posedge sys_clk);
        // Undriven TDO has no pull, so it reads unknown
        tdo = tdoOe_n ? 1'bx : tdoOut;
        pins.tck <= 1'b1;
        repeat (4) @(posedge sys_clk);
        pins.tck <= 1'b0;
    endtask : tick
    task automatic move(input logic [7:0] tms, input int n);
        logic t;
        for (int i = 0; i < n; i++) tick(tms[i], 1'b1, t);
    endtask : move
    task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
        dout = 32'h0000_0000;
        for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
    endtask : shift
    task automatic setTrst(input logic v);
        @(posedge sys_clk) pins.trstN <= v;
    endtask : setTrst
    // Open drain: only pulls low or lets go
    task automatic pull(input logic v);
        @(posedge sys_clk) hostPull_n <= v;
    endtask : pull
endmodule : jdp_jtag_host
